// *** counter_pkg.sv ***
// Purpose: constants, types and register map of the gated up/down counter
// Assumes: one 125 MHz clock, plain register port with one-cycle read latency
// Notes:   Function
// Function
// - continuous mode starts counting from the load value only with the cancel gate function
// - continuous: up pulse at upper limit wraps to lower limit
// - continuous: down pulse at lower limit wraps to upper limit
// - continuous and plain count-once use full signed 32-bit limits
// - overflow and underflow flags stay set until status clear
// - overflow/underflow interrupt raised only when enabled
// - count-once without direction: jump to other limit and close gate
// - interrupt gate function resumes from the held count; after a forward count-once close it reloads the load value
// - cancel gate function reloads the load value on restart
// - count-once forward: at end value minus one, next up pulse reloads and closes
// - count-once forward: going below lower limit does not terminate
// - count, direction and gate filters selectable 1 kHz to 60 kHz
// - latch input has its own selectable filter
// - both interrupts separately enabled, disabled after reset
package counter_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_LOAD   = 4'h1;
   localparam logic [3:0] OFS_END    = 4'h2;
   localparam logic [3:0] OFS_FILT   = 4'h3;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_COUNT  = 4'h5;

   // ctrl field positions
   localparam int CTRL_SW_GATE  = 0;
   localparam int CTRL_ONCE     = 1;
   localparam int CTRL_FWD_DIR  = 2;
   localparam int CTRL_CANCEL   = 3;
   localparam int CTRL_HW_EN    = 4;
   localparam int CTRL_OFL_IE   = 5;
   localparam int CTRL_UFL_IE   = 6;
   localparam int CTRL_STS_CLR  = 7;  // write-one pulse, reads zero
   localparam logic [7:0] CTRL_RST = 8'h00;

   // filter select codes: 0=1k 1=2k 2=5k 3=10k 4=30k 5=60k
   localparam logic [2:0] FSEL_60K = 3'h5;
   localparam int FSEL_N = 6;

   // shortest pulse in ns, per setting
   localparam int CLK_NS = 8;
   localparam int PULSE_NS [FSEL_N] = '{400000, 200000, 80000, 40000, 13000, 6700};
   // least time rounds up to whole cycles
   function automatic logic [15:0] min_cycles(input logic [2:0] sel);
      int idx;
      idx = (int'(sel) < FSEL_N) ? int'(sel) : FSEL_N - 1;
      return 16'((PULSE_NS[idx] + CLK_NS - 1) / CLK_NS);
   endfunction : min_cycles

   localparam logic signed [31:0] CNT_MAX = 32'sh7fffffff;
   localparam logic signed [31:0] CNT_MIN = 32'sh80000000;

   // filtered field inputs
   typedef struct packed {
      logic pulse;
      logic dir;
      logic gate;
      logic latch;
   } field_t;

   typedef struct packed {
      logic [7:0]         ctrl;
      logic signed [31:0] load;
      logic signed [31:0] end_val;
      logic [2:0]         fsel;
      logic [2:0]         lsel;
      logic signed [31:0] count;
      logic               ofl;
      logic               ufl;
      logic               run;
      logic               auto_closed;
      logic               gate_q;
      logic               pulse_q;
      logic               ofl_irq;
      logic               ufl_irq;
      logic [31:0]        rdata;
   } state_t;

endpackage : counter_pkg

// *** updown_counter.sv ***
// Purpose: gated 32-bit signed up/down counter with filtered field inputs
// Assumes: field inputs synchronous to mclk, srst synchronous active high
// Notes:   interrupt outputs are one-cycle pulses; flags are sticky
module updown_counter (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        srst,
   // register port
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   // field inputs
   input  wire logic        cnt_pulse,
   input  wire logic        cnt_dir,
   input  wire logic        hw_gate,
   input  wire logic        latch_in,
   // events
   output logic             ofl_irq,
   output logic             ufl_irq,
   output logic             gate_open
);

   // ----------------------------------------------------------------
   // input filters
   // ----------------------------------------------------------------
   counter_pkg::state_t s_q;
   counter_pkg::state_t s_d;
   logic [3:0]  raw;
   logic [3:0]  filt;
   logic [15:0] need [4];
   assign raw = {cnt_pulse, cnt_dir, hw_gate, latch_in};

   // filter selection
   // a level is accepted only after holding for the shortest pulse time
   always_comb begin
      need[3] = counter_pkg::min_cycles(s_q.fsel);
      need[2] = counter_pkg::min_cycles(s_q.fsel);
      need[1] = counter_pkg::min_cycles(s_q.fsel);
      need[0] = counter_pkg::min_cycles(s_q.lsel);
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_filt
         logic [15:0] cnt_q;
         logic        lvl_q;
         // counter restarts whenever raw equals the accepted level
         always_ff @(posedge mclk) begin
            if (srst) begin
               cnt_q <= 16'h0000;
               lvl_q <= 1'b0;
            end else if (raw[gi] == lvl_q) begin
               cnt_q <= 16'h0000;
            end else if (cnt_q + 16'h0001 >= need[gi]) begin
               cnt_q <= 16'h0000;
               lvl_q <= raw[gi];
            end else begin
               cnt_q <= cnt_q + 16'h0001;
            end
         end
         assign filt[gi] = lvl_q;
      end
   endgenerate

   counter_pkg::field_t f;
   assign f = '{pulse: filt[3], dir: filt[2], gate: filt[1], latch: filt[0]};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic i_gate;
   logic gate_rise;
   logic step;
   logic up;
   logic signed [31:0] nxt;
   // wrap events of this cycle, so a same-cycle status clear cannot hide them
   logic ofl_set;
   logic ufl_set;

   always_comb begin
      s_d         = s_q;
      s_d.ofl_irq = 1'b0;
      s_d.ufl_irq = 1'b0;
      s_d.rdata   = 32'h00000000;
      ofl_set     = 1'b0;
      ufl_set     = 1'b0;
      // internal gate: software gate and, when enabled, the hardware gate
      i_gate    = s_q.ctrl[counter_pkg::CTRL_SW_GATE] &
                  (~s_q.ctrl[counter_pkg::CTRL_HW_EN] | f.gate);
      gate_rise = i_gate & ~s_q.gate_q;
      s_d.gate_q  = i_gate;
      s_d.pulse_q = f.pulse;
      // one step per filtered rising pulse
      step = f.pulse & ~s_q.pulse_q & s_q.run;
      up   = f.dir;
      nxt  = up ? s_q.count + 32'sh1 : s_q.count - 32'sh1;

      // restart needs a fresh 0-1 gate edge after auto close
      if (gate_rise) begin
         s_d.run         = 1'b1;
         s_d.auto_closed = 1'b0;
         // reload on cancel restart or on restart after a forward count-once close
         if (s_q.ctrl[counter_pkg::CTRL_CANCEL] || s_q.auto_closed &&
             s_q.ctrl[counter_pkg::CTRL_ONCE] && s_q.ctrl[counter_pkg::CTRL_FWD_DIR]) begin
            s_d.count = s_q.load;
         end
         // interrupt mode keeps the held count
      end else if (!i_gate) begin
         s_d.run = 1'b0;
      end else if (step) begin
         if (s_q.ctrl[counter_pkg::CTRL_ONCE] && s_q.ctrl[counter_pkg::CTRL_FWD_DIR]) begin
            // end value minus one then reload and close
            if (up && s_q.count == s_q.end_val - 32'sh1) begin
               s_d.count       = s_q.load;
               s_d.run         = 1'b0;
               s_d.auto_closed = 1'b1;
            end else begin
               // below lower limit just wraps on
               s_d.count = nxt;
            end
         end else if (up && s_q.count == counter_pkg::CNT_MAX) begin
            s_d.count   = counter_pkg::CNT_MIN;
            s_d.ofl     = 1'b1;
            ofl_set     = 1'b1;
            s_d.ofl_irq = s_q.ctrl[counter_pkg::CTRL_OFL_IE];
            if (s_q.ctrl[counter_pkg::CTRL_ONCE]) begin
               s_d.run         = 1'b0;
               s_d.auto_closed = 1'b1;
            end
         end else if (!up && s_q.count == counter_pkg::CNT_MIN) begin
            s_d.count   = counter_pkg::CNT_MAX;
            s_d.ufl     = 1'b1;
            ufl_set     = 1'b1;
            s_d.ufl_irq = s_q.ctrl[counter_pkg::CTRL_UFL_IE];
            if (s_q.ctrl[counter_pkg::CTRL_ONCE]) begin
               s_d.run         = 1'b0;
               s_d.auto_closed = 1'b1;
            end
         end else begin
            s_d.count = nxt;
         end
      end

      // register writes
      if (wr) begin
         unique case (addr)
            counter_pkg::OFS_CTRL: begin
               s_d.ctrl = wdata[7:0] & ~(8'h01 << counter_pkg::CTRL_STS_CLR);
               // clear loses to a same-cycle flag set
               if (wdata[counter_pkg::CTRL_STS_CLR]) begin
                  s_d.ofl = ofl_set;
                  s_d.ufl = ufl_set;
               end
            end
            counter_pkg::OFS_LOAD:  s_d.load    = wdata;
            counter_pkg::OFS_END:   s_d.end_val = wdata;
            counter_pkg::OFS_FILT: begin
               s_d.fsel = wdata[2:0];
               s_d.lsel = wdata[6:4];
            end
            default: ;
         endcase
      end

      // reads: data stands in the following cycle only
      if (rd) begin
         unique case (addr)
            counter_pkg::OFS_CTRL:   s_d.rdata = {24'h000000, s_q.ctrl};
            counter_pkg::OFS_LOAD:   s_d.rdata = s_q.load;
            counter_pkg::OFS_END:    s_d.rdata = s_q.end_val;
            counter_pkg::OFS_FILT:   s_d.rdata = {25'h0000000, s_q.lsel, 1'b0, s_q.fsel};
            counter_pkg::OFS_STATUS: s_d.rdata = {27'h0000000, s_q.auto_closed,
                                                  s_q.run, s_q.ufl, s_q.ofl, f.latch};
            counter_pkg::OFS_COUNT:  s_d.rdata = s_q.count;
            default:                 s_d.rdata = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         s_q       <= '0;
         s_q.ctrl  <= counter_pkg::CTRL_RST;
         s_q.fsel  <= counter_pkg::FSEL_60K;
         s_q.lsel  <= counter_pkg::FSEL_60K;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata     = s_q.rdata;
   assign ofl_irq   = s_q.ofl_irq;
   assign ufl_irq   = s_q.ufl_irq;
   assign gate_open = s_q.run;

endmodule : updown_counter

// *** counter_props.sv ***
// Purpose: port checks of the counter
// Assumes: mode bits mirrored from ctrl writes
// Notes:   irq outputs are one-cycle pulses
module counter_props (
   // clock, reset, bus
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic [3:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   // events
   input wire logic        ofl_irq,
   input wire logic        ufl_irq,
   input wire logic        gate_open
);
   logic [7:0] ctrl_q;
   logic       ev;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // mode bits are not on the pins, so shadow them
   always_ff @(posedge mclk) begin
      if (srst)
         ctrl_q <= 8'h00;
      else if (wr && addr == counter_pkg::OFS_CTRL)
         ctrl_q <= wdata[7:0];
   end
   assign ev = ofl_irq | ufl_irq;
   property p_gap; ofl_irq |=> !ev [*8]; endproperty
   a_gap: assert property (p_gap) else $error("irq gap");
   property p_oen; ofl_irq |-> ctrl_q[5]; endproperty
   a_oen: assert property (p_oen) else $error("ofl irq masked");
   property p_uen; ufl_irq |-> ctrl_q[6]; endproperty
   a_uen: assert property (p_uen) else $error("ufl irq masked");
   property p_once; ev && ctrl_q[1] && !ctrl_q[2] |-> !gate_open; endproperty
   a_once: assert property (p_once) else $error("once not closed");
   property p_cont; ev && !ctrl_q[1] |-> gate_open; endproperty
   a_cont: assert property (p_cont) else $error("wrap stopped");
   property p_off; !ctrl_q[0] [*3] |-> !gate_open; endproperty
   a_off: assert property (p_off) else $error("gate open");
   property p_run; ev |-> $past(gate_open); endproperty
   a_run: assert property (p_run) else $error("count while closed");
   property p_rd; !$past(rd) |-> rdata == 32'h0; endproperty
   a_rd: assert property (p_rd) else $error("rdata idle");
   c_ofl: cover property (ofl_irq);
   c_ufl: cover property (ufl_irq);
   c_cls: cover property ($fell(gate_open) && ctrl_q[1]);
endmodule : counter_props

// *** field_src.sv ***
// Purpose: field side: pulses, direction, gate, latch
// Assumes: lines change after mclk rising edges
// Notes:   a short len probes the input filter
module field_src (
   // clock
   input wire logic mclk,
   // field lines
   output logic     cnt_pulse,
   output logic     cnt_dir,
   output logic     hw_gate,
   output logic     latch_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {cnt_pulse, cnt_dir, hw_gate, latch_in} = 4'h4;
   end
   task pulse(input logic up, input int len);
      cnt_dir <= up;
      repeat (len) @(posedge mclk);
      cnt_pulse <= 1'b1;
      repeat (len) @(posedge mclk);
      cnt_pulse <= 1'b0;
      repeat (len) @(posedge mclk);
   endtask : pulse
   task level(input logic g, input logic l, input int len);
      hw_gate  <= g;
      latch_in <= l;
      repeat (len) @(posedge mclk);
   endtask : level
endmodule : field_src

// *** updown_counter_tb_top.sv ***
// Purpose: register level test of the counter
// Assumes: filters at 60 kHz, 838-cycle hold
// Notes:   levels held 850 cycles to pass filter
module updown_counter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD = 850;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic        cnt_pulse, cnt_dir, hw_gate, latch_in;
   logic        ofl_irq, ufl_irq, gate_open;
   int          num_errors = 0;
   int          comparisons = 0;
   int          n_ofl = 0;
   int          n_ufl = 0;
   always #4 mclk = ~mclk;
   updown_counter u_updown_counter (.mclk, .srst, .addr, .wdata, .wr, .rd, .rdata,
      .cnt_pulse, .cnt_dir, .hw_gate, .latch_in, .ofl_irq, .ufl_irq, .gate_open);
   field_src u_field_src (.mclk, .cnt_pulse, .cnt_dir, .hw_gate, .latch_in);
   // tally irq pulses
   always @(posedge mclk) begin
      n_ofl += int'(ofl_irq === 1'b1);
      n_ufl += int'(ufl_irq === 1'b1);
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task wr_reg(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask : wr_reg
   task rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk(rdata & m, e);
      @(posedge mclk);
   endtask : rd_chk
   task rd_cnt(input logic [31:0] e);
      rd_chk(counter_pkg::OFS_COUNT, e, 32'hffffffff);
   endtask : rd_cnt
   // gate rise needs a few cycles to land
   task open_gate(input logic [31:0] d);
      wr_reg(counter_pkg::OFS_CTRL, d);
      repeat (3) @(posedge mclk);
   endtask : open_gate
   task finish_test;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test
   // hang guard
   initial begin
      repeat (100000) @(posedge mclk);
      num_errors++;
      finish_test;
   end
   initial begin
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      rd_chk(counter_pkg::OFS_CTRL, 32'h0, 32'hffffffff);
      rd_chk(counter_pkg::OFS_FILT, 32'h55, 32'hff);
      rd_chk(4'hf, 32'h0, 32'hffffffff);
      // continuous wraps
      wr_reg(counter_pkg::OFS_LOAD, 32'h7fffffff);
      open_gate(32'h29);
      rd_cnt(32'h7fffffff);
      u_field_src.pulse(1'b1, HOLD);
      rd_cnt(32'h80000000);
      chk(32'(n_ofl), 32'h1);
      u_field_src.pulse(1'b0, HOLD);
      rd_cnt(32'h7fffffff);
      rd_chk(counter_pkg::OFS_STATUS, 32'h0e, 32'h0e);
      chk(32'(n_ufl), 32'h0);
      wr_reg(counter_pkg::OFS_CTRL, 32'ha9);
      rd_chk(counter_pkg::OFS_STATUS, 32'h08, 32'h0e);
      u_field_src.pulse(1'b1, 400);
      rd_cnt(32'h7fffffff);
      // count once, cancel then interrupt
      wr_reg(counter_pkg::OFS_CTRL, 32'h0a);
      open_gate(32'h0b);
      u_field_src.pulse(1'b1, HOLD);
      chk(gate_open, 1'b0);
      u_field_src.pulse(1'b1, HOLD);
      rd_cnt(32'h80000000);
      wr_reg(counter_pkg::OFS_CTRL, 32'h0a);
      open_gate(32'h0b);
      rd_cnt(32'h7fffffff);
      wr_reg(counter_pkg::OFS_CTRL, 32'h02);
      open_gate(32'h03);
      u_field_src.pulse(1'b1, HOLD);
      wr_reg(counter_pkg::OFS_CTRL, 32'h42);
      open_gate(32'h43);
      rd_cnt(32'h80000000);
      u_field_src.pulse(1'b0, HOLD);
      rd_cnt(32'h7fffffff);
      chk(32'(n_ufl), 32'h1);
      chk(gate_open, 1'b0);
      // count once forward to end value
      wr_reg(counter_pkg::OFS_LOAD, 32'h0);
      wr_reg(counter_pkg::OFS_END, 32'h2);
      wr_reg(counter_pkg::OFS_CTRL, 32'h0e);
      open_gate(32'h0f);
      u_field_src.pulse(1'b1, HOLD);
      rd_cnt(32'h1);
      u_field_src.pulse(1'b1, HOLD);
      rd_cnt(32'h0);
      chk(gate_open, 1'b0);
      wr_reg(counter_pkg::OFS_LOAD, 32'h80000000);
      wr_reg(counter_pkg::OFS_CTRL, 32'h46);
      open_gate(32'h47);
      u_field_src.pulse(1'b0, HOLD);
      chk(gate_open, 1'b1);
      // hardware gate and latch pass their filters
      open_gate(32'h91);
      chk(gate_open, 1'b0);
      u_field_src.level(1'b1, 1'b1, HOLD);
      chk(gate_open, 1'b1);
      u_field_src.level(1'b1, 1'b0, 400);
      rd_chk(counter_pkg::OFS_STATUS, 32'h09, 32'h0f);
      finish_test;
   end
endmodule : updown_counter_tb_top
bind updown_counter counter_props u_counter_props (.mclk, .srst, .addr, .wdata, .wr,
   .rd, .rdata, .ofl_irq, .ufl_irq, .gate_open);
